// ### echo_burst_map.svh
`ifndef ECHO_BURST_MAP_SVH
`define ECHO_BURST_MAP_SVH

// Register byte offsets
`define EB_OFF_CTRL 12'h000
`define EB_OFF_RECLEN 12'h004
`define EB_OFF_STATUS 12'h008
`define EB_OFF_CMD 12'h00C
// Capture memory window, paddr[11:9] value (0x200 to 0x3FC)
`define EB_MEM_WIN 3'h1

// Control fields
`define EB_CTRL_CAPEN 0
`define EB_CTRL_TAP_LSB 4
`define EB_CTRL_WIDE 8
`define EB_CTRL_GAIN_LSB 12
`define EB_RECLEN_P2_LSB 4

// Reset values
`define EB_CTRL_RST 16'h0000
`define EB_RECLEN_RST 8'h00

// Tap selector values
`define EB_TAP_LPF 3'h1
`define EB_TAP_LIMIT 3'h5

// Timing
`define EB_CLK_PERIOD_NS 8
`define EB_SAMPLE_PERIOD_US 1
`define EB_SAMPLE_CYCLES ((`EB_SAMPLE_PERIOD_US * 1000) / `EB_CLK_PERIOD_NS)

`endif

// ### echo_burst_pkg.sv
package echo_burst_pkg;

  typedef enum logic [2:0] {
    CMD_BL_P1 = 3'b000,
    CMD_BL_P2 = 3'b001,
    CMD_LO_P1 = 3'b010,
    CMD_LO_P2 = 3'b011,
    CMD_TEMP = 3'b100
  } cmd_e;

  typedef enum logic {
    CAP_IDLE = 1'b0,
    CAP_RUN = 1'b1
  } capture_state_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIAG = 2'b01,
    ST_DATA = 2'b10,
    ST_SUM = 2'b11
  } stream_state_e;

endpackage : echo_burst_pkg

// ### echo_mem.sv
`timescale 1ns/100ps

module echo_mem (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [6:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:127];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : echo_mem

// ### echo_capture_and_raw_burst.sv
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`include "echo_burst_map.svh"

// Function
// - Capture enable makes any of the four run commands capture echoes.
// - Pull the single-wire bus pin low for the whole capture record.
// - Captured echoes live in a 128-byte memory, one byte per location.
// - Down-sampling ratio follows the record length of the run's preset.
// - Each location keeps only the peak sample of its group.
// - Locations fill in time order, blocks of length/128 from sample zero.
// - Data path gives one sample per microsecond.
// - Capture enable switches object detection and measurement off.
// - Tap select 1 to 4 enables streaming and disables detection.
// - Streaming only in synchronous USART mode with master clock.
// - Tap 1 to 4: run or temperature command streams the tap at once.
// - Stream is diagnostic byte, data bytes, then checksum over all.
// - Samples per stream equal the preset record time in microseconds in width 0, half of it in width 1.
// - Width 0: one byte per sample, byte picked by gain select.
// - Width 1: twelve-bit samples, every second sample sent.
// - Twelve-bit: low byte first, high byte carries a sample counter.
// - Nonlinear scaling only for the low-pass tap, bypassed otherwise.
// - Frames are eight bits, LSB first, no start, stop or gaps.
module echo_capture_and_raw_burst (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Data path taps, same clock domain
  input wire logic [11:0] dp_lpf,
  input wire logic [11:0] dp_tap2,
  input wire logic [11:0] dp_tap3,
  input wire logic [11:0] dp_tap4,
  // Stream header
  input wire logic [7:0] diag_byte,
  // Synchronous USART
  input wire logic sclk_in,
  output logic txd,
  // Single-wire bus pin
  input wire logic io_in,
  output logic io_out,
  output logic io_oe_n,
  // Detection control
  output logic object_detect_enable,
  output logic scaling_enable
);

  // Record length in samples, (setting + 1) * 4096
  function automatic logic [16:0] rec_samples(input logic [3:0] r);
    logic [4:0] units;
    units = {1'b0, r} + 5'h01;
    rec_samples = {units, 12'h000};
  endfunction : rec_samples

  // Compressive scaling for the low-pass tap
  function automatic logic [11:0] nl_scale(input logic [11:0] x);
    logic [11:0] d;
    d = x - 12'h400;
    if (x < 12'h400) begin
      nl_scale = {x[10:0], 1'b0};
    end else begin
      nl_scale = 12'h600 + {2'b00, d[11:2]};
    end
  endfunction : nl_scale

  function automatic logic [7:0] pick_byte(input logic [11:0] x,
                                           input logic [2:0] t,
                                           input logic [1:0] g);
    if (t == `EB_TAP_LPF) begin
      case (g)
        2'h0: pick_byte = x[11:4];
        2'h1: pick_byte = x[10:3];
        2'h2: pick_byte = x[9:2];
        default: pick_byte = x[7:0];
      endcase
    end else begin
      pick_byte = (g == 2'h0) ? x[11:4] : x[7:0];
    end
  endfunction : pick_byte

  // Ones-complement style running sum
  function automatic logic [7:0] sum_add(input logic [7:0] a,
                                         input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    sum_add = s[7:0] + {7'h00, s[8]};
  endfunction : sum_add

  logic [15:0] ctrl, next_ctrl;
  logic [7:0] reclen, next_reclen;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [6:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick, phase, next_phase;
  logic [11:0] samp_latest, next_samp_latest, samp_even, next_samp_even;
  logic sclk_meta, sclk_sync, sclk_prev, io_meta, io_sync, sync_mode;
  logic next_sync_mode;
  echo_burst_pkg::capture_state_e cap_state, next_cap_state;
  logic [16:0] cap_sample_cnt, next_cap_sample_cnt;
  logic [16:0] cap_total, next_cap_total;
  logic [9:0] cap_block_cnt, next_cap_block_cnt;
  logic [9:0] cap_block_len, next_cap_block_len;
  logic [6:0] cap_addr, next_cap_addr;
  logic [7:0] cap_peak, next_cap_peak;
  logic cap_done, next_cap_done;
  logic mem_we, next_mem_we;
  logic [6:0] mem_waddr, next_mem_waddr;
  logic [7:0] mem_wdata, next_mem_wdata, mem_rdata;
  echo_burst_pkg::stream_state_e st_state, next_st_state;
  logic [7:0] st_shift, next_st_shift, st_sum, next_st_sum;
  logic [2:0] st_bit, next_st_bit, st_tap, next_st_tap;
  logic [1:0] st_gain, next_st_gain;
  logic st_wide, next_st_wide, st_hi, next_st_hi, st_last, next_st_last;
  logic [16:0] st_left, next_st_left;
  logic [11:0] st_hold, next_st_hold;
  logic [3:0] st_cnt4, next_st_cnt4;
  logic next_txd, next_io_oe_n, next_detect, next_scale;

  logic cap_en, wide, tap_valid, setup, wr_fire, is_mem, cmd_go, is_run;
  logic cap_go, stream_go, preset2, fall, rise;
  logic [2:0] tap;
  logic [1:0] gain;
  logic [16:0] run_len;
  logic [7:0] sample8;

  assign cap_en = ctrl[`EB_CTRL_CAPEN];
  assign tap = ctrl[`EB_CTRL_TAP_LSB +: 3];
  assign wide = ctrl[`EB_CTRL_WIDE];
  assign gain = ctrl[`EB_CTRL_GAIN_LSB +: 2];
  assign tap_valid = (tap != 3'h0) && (tap < `EB_TAP_LIMIT);
  assign setup = psel && !penable;
  assign wr_fire = psel && penable && pready && pwrite;
  assign is_mem = (paddr[11:9] == `EB_MEM_WIN);
  assign cmd_go = wr_fire && (paddr == `EB_OFF_CMD)
                  && (pwdata[2:0] <= echo_burst_pkg::CMD_TEMP);
  assign is_run = (pwdata[2:0] <= echo_burst_pkg::CMD_LO_P2);
  assign preset2 = pwdata[0] && !pwdata[2];
  assign run_len = preset2 ?
                   rec_samples(reclen[`EB_RECLEN_P2_LSB +: 4]) :
                   rec_samples(reclen[3:0]);
  assign cap_go = cmd_go && is_run && cap_en
                  && (cap_state == echo_burst_pkg::CAP_IDLE);
  assign stream_go = cmd_go && tap_valid && sync_mode
                     && (st_state == echo_burst_pkg::ST_IDLE);
  assign fall = sclk_prev && !sclk_sync;
  assign rise = !sclk_prev && sclk_sync;
  assign sample8 = dp_lpf[11:4];

  // APB registers and answers
  always_comb begin
    next_ctrl = ctrl;
    next_reclen = reclen;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (wr_fire && (paddr == `EB_OFF_CTRL)) begin
      next_ctrl = pwdata[15:0];
    end
    if (wr_fire && (paddr == `EB_OFF_RECLEN)) begin
      next_reclen = pwdata[7:0];
    end
    if (setup && !is_mem) begin
      next_pready = 1'b1;
      case (paddr)
        `EB_OFF_CTRL: next_prdata = {16'h0000, ctrl};
        `EB_OFF_RECLEN: next_prdata = {24'h00_0000, reclen};
        `EB_OFF_STATUS: next_prdata = {26'h000_0000, io_sync, sync_mode,
            object_detect_enable, cap_done,
            st_state != echo_burst_pkg::ST_IDLE,
            cap_state == echo_burst_pkg::CAP_RUN};
        `EB_OFF_CMD: next_prdata = 32'h0000_0000;
        default: begin
          next_prdata = 32'h0000_0000;
          next_pslverr = 1'b1;
        end
      endcase
    end else if (psel && penable && !pready && is_mem) begin
      next_pready = 1'b1;
      next_prdata = {24'h00_0000, mem_rdata};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `EB_CTRL_RST;
      reclen <= `EB_RECLEN_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      reclen <= next_reclen;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Microsecond tick, sample holds and pin synchronisers
  always_comb begin
    logic [2:0] samp_sel;
    samp_sel = (st_state == echo_burst_pkg::ST_IDLE) ? tap : st_tap;
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 7'h01;
    next_phase = phase;
    next_samp_latest = samp_latest;
    next_samp_even = samp_even;
    next_sync_mode = sync_mode || rise;
    if (tick_cnt == 7'(`EB_SAMPLE_CYCLES - 1)) begin
      next_tick_cnt = 7'h00;
      next_tick = 1'b1;
    end
    if (tick) begin
      case (samp_sel)
        3'h1: next_samp_latest = nl_scale(dp_lpf);
        3'h2: next_samp_latest = dp_tap2;
        3'h3: next_samp_latest = dp_tap3;
        3'h4: next_samp_latest = dp_tap4;
        default: next_samp_latest = 12'h000;
      endcase
      next_phase = !phase;
      if (!phase) begin
        next_samp_even = next_samp_latest;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 7'h00;
      tick <= 1'b0;
      phase <= 1'b0;
      samp_latest <= 12'h000;
      samp_even <= 12'h000;
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      io_meta <= 1'b1;
      io_sync <= 1'b1;
      sync_mode <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
      phase <= next_phase;
      samp_latest <= next_samp_latest;
      samp_even <= next_samp_even;
      sclk_meta <= sclk_in;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      io_meta <= io_in;
      io_sync <= io_meta;
      sync_mode <= next_sync_mode;
    end
  end

  // Echo capture with peak hold
  always_comb begin
    next_cap_state = cap_state;
    next_cap_sample_cnt = cap_sample_cnt;
    next_cap_total = cap_total;
    next_cap_block_cnt = cap_block_cnt;
    next_cap_block_len = cap_block_len;
    next_cap_addr = cap_addr;
    next_cap_peak = cap_peak;
    next_cap_done = cap_done;
    next_mem_we = 1'b0;
    next_mem_waddr = cap_addr;
    next_mem_wdata = cap_peak;
    case (cap_state)
      echo_burst_pkg::CAP_IDLE: begin
        if (cap_go) begin
          next_cap_state = echo_burst_pkg::CAP_RUN;
          next_cap_sample_cnt = 17'h0_0000;
          next_cap_total = run_len;
          next_cap_block_len = run_len[16:7];
          next_cap_block_cnt = 10'h000;
          next_cap_addr = 7'h00;
          next_cap_peak = 8'h00;
          next_cap_done = 1'b0;
        end
      end
      echo_burst_pkg::CAP_RUN: begin
        if (tick) begin
          if ((cap_block_cnt == 10'h000) || (sample8 > cap_peak)) begin
            next_cap_peak = sample8;
          end
          next_cap_block_cnt = cap_block_cnt + 10'h001;
          if (cap_block_cnt == cap_block_len - 10'h001) begin
            next_mem_we = 1'b1;
            next_mem_wdata = next_cap_peak;
            next_cap_addr = cap_addr + 7'h01;
            next_cap_block_cnt = 10'h000;
          end
          next_cap_sample_cnt = cap_sample_cnt + 17'h0_0001;
          if (cap_sample_cnt == cap_total - 17'h0_0001) begin
            next_cap_state = echo_burst_pkg::CAP_IDLE;
            next_cap_done = 1'b1;
          end
        end
      end
      default: next_cap_state = echo_burst_pkg::CAP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_state <= echo_burst_pkg::CAP_IDLE;
      cap_sample_cnt <= 17'h0_0000;
      cap_total <= 17'h0_0000;
      cap_block_cnt <= 10'h000;
      cap_block_len <= 10'h000;
      cap_addr <= 7'h00;
      cap_peak <= 8'h00;
      cap_done <= 1'b0;
      mem_we <= 1'b0;
      mem_waddr <= 7'h00;
      mem_wdata <= 8'h00;
    end else begin
      cap_state <= next_cap_state;
      cap_sample_cnt <= next_cap_sample_cnt;
      cap_total <= next_cap_total;
      cap_block_cnt <= next_cap_block_cnt;
      cap_block_len <= next_cap_block_len;
      cap_addr <= next_cap_addr;
      cap_peak <= next_cap_peak;
      cap_done <= next_cap_done;
      mem_we <= next_mem_we;
      mem_waddr <= next_mem_waddr;
      mem_wdata <= next_mem_wdata;
    end
  end

  echo_mem u_mem (
    .clk(pclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(paddr[8:2]),
    .rdata(mem_rdata)
  );

  // Raw burst serializer, shifts on master clock falling edges
  always_comb begin
    logic [7:0] dbyte;
    dbyte = 8'h00;
    next_st_state = st_state;
    next_st_shift = st_shift;
    next_st_sum = st_sum;
    next_st_bit = st_bit;
    next_st_tap = st_tap;
    next_st_gain = st_gain;
    next_st_wide = st_wide;
    next_st_hi = st_hi;
    next_st_last = st_last;
    next_st_left = st_left;
    next_st_hold = st_hold;
    next_st_cnt4 = st_cnt4;
    next_txd = txd;
    if (st_state == echo_burst_pkg::ST_IDLE) begin
      next_txd = 1'b1;
      if (stream_go) begin
        next_st_state = echo_burst_pkg::ST_DIAG;
        next_st_tap = tap;
        next_st_gain = gain;
        next_st_wide = wide;
        next_st_shift = diag_byte;
        next_st_sum = diag_byte;
        next_txd = diag_byte[0];
        next_st_bit = 3'h0;
        next_st_left = wide ? {1'b0, run_len[16:1]} : run_len;
        next_st_hi = 1'b0;
        next_st_last = 1'b0;
        next_st_cnt4 = 4'h0;
      end
    end else if (fall) begin
      if (st_bit != 3'h7) begin
        next_st_shift = {1'b0, st_shift[7:1]};
        next_txd = st_shift[1];
        next_st_bit = st_bit + 3'h1;
      end else begin
        next_st_bit = 3'h0;
        if (st_state == echo_burst_pkg::ST_SUM) begin
          next_st_state = echo_burst_pkg::ST_IDLE;
          next_txd = 1'b1;
        end else if (st_state == echo_burst_pkg::ST_DATA && st_last) begin
          dbyte = ~st_sum;
          next_st_state = echo_burst_pkg::ST_SUM;
          next_st_shift = dbyte;
          next_txd = dbyte[0];
        end else begin
          next_st_state = echo_burst_pkg::ST_DATA;
          if (!st_wide) begin
            dbyte = pick_byte(samp_latest, st_tap, st_gain);
            next_st_left = st_left - 17'h0_0001;
            next_st_last = (st_left == 17'h0_0001);
          end else if (!st_hi) begin
            dbyte = samp_even[7:0];
            next_st_hold = samp_even;
            next_st_hi = 1'b1;
          end else begin
            dbyte = {st_cnt4, st_hold[11:8]};
            next_st_cnt4 = st_cnt4 + 4'h1;
            next_st_hi = 1'b0;
            next_st_left = st_left - 17'h0_0001;
            next_st_last = (st_left == 17'h0_0001);
          end
          next_st_sum = sum_add(st_sum, dbyte);
          next_st_shift = dbyte;
          next_txd = dbyte[0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_state <= echo_burst_pkg::ST_IDLE;
      st_shift <= 8'h00;
      st_sum <= 8'h00;
      st_bit <= 3'h0;
      st_tap <= 3'h0;
      st_gain <= 2'h0;
      st_wide <= 1'b0;
      st_hi <= 1'b0;
      st_last <= 1'b0;
      st_left <= 17'h0_0000;
      st_hold <= 12'h000;
      st_cnt4 <= 4'h0;
      txd <= 1'b1;
    end else begin
      st_state <= next_st_state;
      st_shift <= next_st_shift;
      st_sum <= next_st_sum;
      st_bit <= next_st_bit;
      st_tap <= next_st_tap;
      st_gain <= next_st_gain;
      st_wide <= next_st_wide;
      st_hi <= next_st_hi;
      st_last <= next_st_last;
      st_left <= next_st_left;
      st_hold <= next_st_hold;
      st_cnt4 <= next_st_cnt4;
      txd <= next_txd;
    end
  end

  // Pin and detection outputs
  always_comb begin
    next_io_oe_n = (next_cap_state != echo_burst_pkg::CAP_RUN);
    next_detect = !cap_en && !tap_valid;
    next_scale = (tap == `EB_TAP_LPF);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_out <= 1'b0;
      io_oe_n <= 1'b1;
      object_detect_enable <= 1'b1;
      scaling_enable <= 1'b0;
    end else begin
      io_out <= 1'b0;
      io_oe_n <= next_io_oe_n;
      object_detect_enable <= next_detect;
      scaling_enable <= next_scale;
    end
  end

endmodule : echo_capture_and_raw_burst

// ### echo_burst_chk.sv
`timescale 1ns/100ps
`include "echo_burst_map.svh"

module echo_burst_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and control
  input wire logic io_out,
  input wire logic io_oe_n,
  input wire logic object_detect_enable,
  input wire logic scaling_enable
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_pin_low_only: assert property (io_out == 1'b0)
    else $error("io_out driven high");
  a_pin_hold: assert property ($fell(io_oe_n) |-> !io_oe_n [*8])
    else $error("capture pin released early");
  a_capture_no_detect: assert property (
    !io_oe_n |-> !object_detect_enable)
    else $error("detection on during capture");
  a_lpf_scale_detect: assert property (
    scaling_enable |-> !object_detect_enable)
    else $error("detection on with low-pass tap");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_reg_no_wait: assert property (
    psel && !penable && paddr[11:9] != `EB_MEM_WIN ##1 psel && penable
    |-> pready)
    else $error("register access not zero wait");
  a_mem_one_wait: assert property (
    psel && !penable && paddr[11:9] == `EB_MEM_WIN ##1 psel && penable
    |-> !pready ##1 pready)
    else $error("memory access not one wait");
endmodule : echo_burst_chk

bind echo_capture_and_raw_burst echo_burst_chk u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .pready(pready),
  .pslverr(pslverr),
  .io_out(io_out),
  .io_oe_n(io_oe_n),
  .object_detect_enable(object_detect_enable),
  .scaling_enable(scaling_enable)
);

// ### usart_master_model.sv
`timescale 1ns/100ps

module usart_master_model (
  // Control
  input wire logic run,
  input wire logic listen,
  // Link
  output logic sclk,
  input wire logic txd,
  // Received bytes
  output logic [7:0] rx_bytes [0:7],
  output int rx_count
);
  logic [7:0] shift;
  int bit_cnt;

  // Clock stands low while run is low
  initial begin
    sclk = 1'b0;
    rx_count = 0;
    bit_cnt = 0;
    #3;
    forever begin
      #80;
      sclk = run ? ~sclk : 1'b0;
    end
  end

  // Sample on rising edge, LSB first, no framing bits
  always @(posedge sclk) begin
    if (!listen) begin
      bit_cnt = 0;
      rx_count = 0;
    end else begin
      shift = {txd, shift[7:1]};
      bit_cnt = bit_cnt + 1;
      if (bit_cnt == 8) begin
        if (rx_count < 8) begin
          rx_bytes[rx_count] = shift;
        end
        rx_count = rx_count + 1;
        bit_cnt = 0;
      end
    end
  end
endmodule : usart_master_model

// ### echo_capture_and_raw_burst_tb.sv
`timescale 1ns/100ps
`include "echo_burst_map.svh"

module echo_capture_and_raw_burst_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, dp_lpf, dp_tap2, dp_tap3, dp_tap4;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] diag_byte;
  logic sclk, txd, io_in, io_out, io_oe_n, detect, scale, run, listen;
  logic [7:0] rx_bytes [0:7];
  logic [7:0] exp_b [0:6];
  int rx_count, fail_count, tests_run;

  // Pull-up on the single-wire pin
  assign io_in = io_oe_n ? 1'b1 : io_out;

  echo_capture_and_raw_burst dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dp_lpf(dp_lpf),
    .dp_tap2(dp_tap2), .dp_tap3(dp_tap3), .dp_tap4(dp_tap4),
    .diag_byte(diag_byte), .sclk_in(sclk), .txd(txd), .io_in(io_in),
    .io_out(io_out), .io_oe_n(io_oe_n), .object_detect_enable(detect),
    .scaling_enable(scale));

  usart_master_model u_master (.run(run), .listen(listen), .sclk(sclk),
    .txd(txd), .rx_bytes(rx_bytes), .rx_count(rx_count));

  always #4 pclk = ~pclk;

  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task reset_dut();
    presetn <= 1'b0;
    run <= 1'b0;
    listen <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : reset_dut

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      fail_count++;
      stop_test();
    end
  endtask : apb

  // Enter sync mode, start a stream, collect n bytes
  task stream(input logic [31:0] ctrl, input int n);
    int i;
    reset_dut();
    apb(1'b1, `EB_OFF_CTRL, ctrl);
    run <= 1'b1;
    repeat (300) @(posedge pclk);
    run <= 1'b0;
    listen <= 1'b1;
    repeat (30) @(posedge pclk);
    apb(1'b1, `EB_OFF_CMD, 32'h0000_0004);
    run <= 1'b1;
    for (i = 0; i < 4000 && rx_count < n; i++) @(posedge pclk);
    run <= 1'b0;
    if (rx_count < n) begin
      fail_count++;
      stop_test();
    end
    for (i = 0; i < n; i++) check(32'(rx_bytes[i]), 32'(exp_b[i]));
  endtask : stream

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    dp_lpf = 12'h3C7;
    dp_tap2 = 12'hA5C;
    dp_tap3 = 12'h7E1;
    dp_tap4 = 12'h0F0;
    diag_byte = 8'h3C;
    run = 1'b0;
    listen = 1'b0;
    fail_count = 0;
    tests_run = 0;
    reset_dut();
    check(32'(txd), 32'h0000_0001);
    check(32'(io_oe_n), 32'h0000_0001);
    check(32'(detect), 32'h0000_0001);
    apb(1'b0, `EB_OFF_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0028);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    // Every tap value, boundaries 0 and 5 included
    for (int t = 0; t < 8; t++) begin
      apb(1'b1, `EB_OFF_CTRL, 32'(t) << `EB_CTRL_TAP_LSB);
      repeat (2) @(posedge pclk);
      check(32'(detect), 32'((t == 0) || (t > 4)));
      check(32'(scale), 32'(t == 1));
    end
    // Every run command, temperature read must not capture
    for (int c = 0; c < 5; c++) begin
      reset_dut();
      apb(1'b1, `EB_OFF_RECLEN, 32'h0000_0010);
      apb(1'b1, `EB_OFF_CTRL, 32'h0000_0001);
      apb(1'b0, 12'h200, 32'h0000_0000);
      check(32'(err), 32'h0000_0000);
      apb(1'b1, `EB_OFF_CMD, 32'(c));
      repeat (2) @(posedge pclk);
      check(32'(io_oe_n), 32'(c == 4));
      check(32'(io_out), 32'h0000_0000);
      check(32'(detect), 32'h0000_0000);
      apb(1'b0, `EB_OFF_STATUS, 32'h0000_0000);
      check(rd & 32'h0000_0021, (c == 4) ? 32'h20 : 32'h1);
    end
    exp_b = '{8'h3C, 8'hA5, 8'hA5, 8'h00, 8'h00, 8'h00, 8'h00};
    stream(32'h0000_0020, 3);
    exp_b = '{8'h3C, 8'h5C, 8'h5C, 8'h00, 8'h00, 8'h00, 8'h00};
    stream(32'h0000_1020, 3);
    exp_b = '{8'h3C, 8'hF1, 8'hF1, 8'h00, 8'h00, 8'h00, 8'h00};
    stream(32'h0000_1010, 3);
    exp_b = '{8'h3C, 8'hE1, 8'h07, 8'hE1, 8'h17, 8'hE1, 8'h27};
    stream(32'h0000_0130, 7);
    stop_test();
  end
endmodule : echo_capture_and_raw_burst_tb
